// [logic/stl_linkage.sv]
`timescale 1ns/1ps
`include "stl_regs.svh"
// How it works
// (R1) stacks grow downward, each push takes the next lower location
// (R2) pointer holds address of last stored item; below it is free
// (R3) any register but pc may be a stack pointer; the sp stack uses register 6
// (R4) non-sp stacks may hold words or bytes per move width
// (R5) register 6 stays even and only carries word traffic
// (R6) push lowers the pointer first then writes at new address
// (R7) pop reads at pointer then raises it past the item
// (R8) call first pushes the linkage register onto the sp stack
// (R9) call then loads linkage with pc and jumps to entry
// (R10) autoincrement argument fetch via linkage advances it to next argument
// (R11) pc and status are saved and restored on the sp stack
// (R12) return copies register to pc then pops stack into register
// (R13) interrupt pushes status then pc, then loads both from vector
// (R14) pointer step is two for words, one for bytes, two on sp
module stl_linkage (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire stl_pkg::stl_op_e  i_op,
    input  wire logic [2:0]        i_reg,
    input  wire logic              i_byte,
    input  wire logic [15:0]       i_data,
    input  wire logic [15:0]       i_entry,
    input  wire logic [15:0]       i_vector,
    input  wire logic [15:0]       i_processor_status_word,
    input  wire logic              i_mem_ack,
    input  wire logic [15:0]       i_mem_rdata,
    output logic                   o_busy,
    output logic                   o_mem_req,
    output logic                   o_mem_we,
    output logic                   o_mem_byte,
    output logic      [15:0]       o_mem_addr,
    output logic      [15:0]       o_mem_wdata,
    output logic      [15:0]       o_pop_data,
    output logic                   o_pop_valid,
    output logic      [15:0]       o_processor_status_word,
    output logic                   o_ps_load,
    output logic      [15:0]       o_hardware_stack_pointer,
    output logic      [15:0]       o_program_counter_register,
    output logic                   o_op_error
);
    logic [15:0] regs_r [0:7];
    logic [15:0] regs_nxt [0:7];
    stl_pkg::stl_state_e st_r, st_nxt;
    logic [2:0]  sel_r, sel_nxt;
    logic        byte_r, byte_nxt;
    logic [15:0] hold_r, hold_nxt;
    logic        req_r, req_nxt, we_r, we_nxt, mb_r, mb_nxt;
    logic [15:0] addr_r, addr_nxt, wd_r, wd_nxt;
    logic [15:0] pd_r, pd_nxt, ps_r, ps_nxt;
    logic        pv_r, pv_nxt, psl_r, psl_nxt, err_r, err_nxt;
    logic        busy_r, busy_nxt;
    logic [15:0] dec_val, inc_val, spdec;
    logic        sel_byte;

    // ------------------------------------------------------------
    // pointer arithmetic
    // ------------------------------------------------------------
    assign sel_byte = i_byte;
    stl_step u_dec (.i_reg(i_reg), .i_byte(sel_byte), .i_val(regs_r[i_reg]),
                    .i_up(1'b0), .o_val(dec_val));
    stl_step u_inc (.i_reg(sel_r), .i_byte(byte_r), .i_val(regs_r[sel_r]),
                    .i_up(1'b1), .o_val(inc_val));
    assign spdec = 16'(regs_r[`STL_SP_IDX] - `STL_WORD_STEP);

    function automatic logic bad_ptr(input logic [2:0] r);
        bad_ptr = (r == `STL_PC_IDX);
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        for (int k = 0; k < 8; k++) regs_nxt[k] = regs_r[k];
        st_nxt = st_r; sel_nxt = sel_r; byte_nxt = byte_r; hold_nxt = hold_r;
        req_nxt = req_r; we_nxt = we_r; mb_nxt = mb_r; addr_nxt = addr_r;
        wd_nxt = wd_r; pd_nxt = pd_r; ps_nxt = ps_r;
        pv_nxt = 1'b0; psl_nxt = 1'b0; err_nxt = 1'b0;
        unique case (st_r)
            stl_pkg::STL_IDLE: begin
                req_nxt = 1'b0;
                sel_nxt = i_reg;
                // byte moves on sp are coerced to words
                byte_nxt = i_byte && (i_reg != `STL_SP_IDX); // [R5]
                unique case (i_op)
                    stl_pkg::STL_OP_PUSH: begin
                        if (bad_ptr(i_reg)) err_nxt = 1'b1; // [R3]
                        else begin
                            regs_nxt[i_reg] = dec_val; // [R6] [R1] [R4]
                            addr_nxt = dec_val; wd_nxt = i_data;
                            mb_nxt = byte_nxt; we_nxt = 1'b1; req_nxt = 1'b1;
                            st_nxt = stl_pkg::STL_PUSH_WR;
                        end
                    end
                    stl_pkg::STL_OP_POP, stl_pkg::STL_OP_ARGINC: begin
                        if (bad_ptr(i_reg) && i_op == stl_pkg::STL_OP_POP) err_nxt = 1'b1;
                        else begin
                            addr_nxt = regs_r[i_reg]; // [R7] [R2] [R10]
                            mb_nxt = byte_nxt; we_nxt = 1'b0; req_nxt = 1'b1;
                            st_nxt = stl_pkg::STL_POP_RD;
                        end
                    end
                    stl_pkg::STL_OP_CALL: begin
                        regs_nxt[`STL_SP_IDX] = spdec; // [R8] [R3]
                        addr_nxt = spdec; wd_nxt = regs_r[i_reg];
                        hold_nxt = i_entry; mb_nxt = 1'b0; we_nxt = 1'b1; req_nxt = 1'b1;
                        st_nxt = stl_pkg::STL_CALL_WR;
                    end
                    stl_pkg::STL_OP_RETURN: begin
                        regs_nxt[`STL_PC_IDX] = regs_r[i_reg]; // [R12]
                        // a byte request must not reach the rti branch of the shared pop
                        byte_nxt = 1'b0;
                        addr_nxt = regs_r[`STL_SP_IDX]; mb_nxt = 1'b0;
                        we_nxt = 1'b0; req_nxt = 1'b1;
                        st_nxt = stl_pkg::STL_RET_RD;
                    end
                    stl_pkg::STL_OP_INTR: begin
                        regs_nxt[`STL_SP_IDX] = spdec; // [R13] [R11]
                        addr_nxt = spdec; wd_nxt = i_processor_status_word;
                        hold_nxt = i_vector; mb_nxt = 1'b0; we_nxt = 1'b1; req_nxt = 1'b1;
                        st_nxt = stl_pkg::STL_INT_PS;
                    end
                    stl_pkg::STL_OP_RTI: begin
                        addr_nxt = regs_r[`STL_SP_IDX]; mb_nxt = 1'b0; // [R11]
                        we_nxt = 1'b0; req_nxt = 1'b1;
                        st_nxt = stl_pkg::STL_RET_RD;
                        sel_nxt = `STL_PC_IDX;
                        byte_nxt = 1'b1; // flags rti in the shared pop path
                    end
                    default: ;
                endcase
            end
            stl_pkg::STL_PUSH_WR, stl_pkg::STL_CALL_WR: if (i_mem_ack) begin
                req_nxt = 1'b0;
                st_nxt = stl_pkg::STL_IDLE;
                if (st_r == stl_pkg::STL_CALL_WR) begin
                    regs_nxt[sel_r] = regs_r[`STL_PC_IDX]; // [R9]
                    regs_nxt[`STL_PC_IDX] = hold_r; // [R9]
                end
            end
            stl_pkg::STL_POP_RD: if (i_mem_ack) begin
                req_nxt = 1'b0;
                pd_nxt = i_mem_rdata; pv_nxt = 1'b1;
                regs_nxt[sel_r] = inc_val; // [R7] [R10] [R14]
                st_nxt = stl_pkg::STL_IDLE;
            end
            stl_pkg::STL_RET_RD: if (i_mem_ack) begin
                regs_nxt[`STL_SP_IDX] = 16'(regs_r[`STL_SP_IDX] + `STL_WORD_STEP);
                if (byte_r) begin
                    regs_nxt[`STL_PC_IDX] = i_mem_rdata; // [R11]
                    addr_nxt = 16'(regs_r[`STL_SP_IDX] + `STL_WORD_STEP);
                    st_nxt = stl_pkg::STL_RTI_PS;
                end else begin
                    regs_nxt[sel_r] = i_mem_rdata; // [R12]
                    req_nxt = 1'b0;
                    st_nxt = stl_pkg::STL_IDLE;
                end
            end
            stl_pkg::STL_RTI_PS: if (i_mem_ack) begin
                regs_nxt[`STL_SP_IDX] = 16'(regs_r[`STL_SP_IDX] + `STL_WORD_STEP);
                ps_nxt = i_mem_rdata; psl_nxt = 1'b1; req_nxt = 1'b0;
                st_nxt = stl_pkg::STL_IDLE;
            end
            stl_pkg::STL_INT_PS: if (i_mem_ack) begin
                regs_nxt[`STL_SP_IDX] = spdec; // [R13]
                addr_nxt = spdec; wd_nxt = regs_r[`STL_PC_IDX];
                st_nxt = stl_pkg::STL_INT_PC;
            end
            stl_pkg::STL_INT_PC: if (i_mem_ack) begin
                addr_nxt = hold_r; we_nxt = 1'b0; // [R13]
                st_nxt = stl_pkg::STL_VEC_PC;
            end
            stl_pkg::STL_VEC_PC: if (i_mem_ack) begin
                regs_nxt[`STL_PC_IDX] = i_mem_rdata;
                addr_nxt = 16'(hold_r + `STL_WORD_STEP);
                st_nxt = stl_pkg::STL_VEC_PS;
            end
            stl_pkg::STL_VEC_PS: if (i_mem_ack) begin
                ps_nxt = i_mem_rdata; psl_nxt = 1'b1; req_nxt = 1'b0;
                st_nxt = stl_pkg::STL_IDLE;
            end
            default: st_nxt = stl_pkg::STL_IDLE;
        endcase
        // sp can never hold an odd address
        regs_nxt[`STL_SP_IDX][0] = 1'b0; // [R5]
        busy_nxt = (st_nxt != stl_pkg::STL_IDLE);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int k = 0; k < 8; k++) regs_r[k] <= `STL_RST_WORD;
            st_r <= stl_pkg::STL_IDLE; sel_r <= 3'h0; byte_r <= 1'b0;
            hold_r <= `STL_RST_WORD; req_r <= 1'b0; we_r <= 1'b0; mb_r <= 1'b0;
            addr_r <= `STL_RST_WORD; wd_r <= `STL_RST_WORD; pd_r <= `STL_RST_WORD;
            ps_r <= `STL_RST_WORD; pv_r <= 1'b0; psl_r <= 1'b0; err_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            for (int k = 0; k < 8; k++) regs_r[k] <= regs_nxt[k];
            st_r <= st_nxt; sel_r <= sel_nxt; byte_r <= byte_nxt; hold_r <= hold_nxt;
            req_r <= req_nxt; we_r <= we_nxt; mb_r <= mb_nxt; addr_r <= addr_nxt;
            wd_r <= wd_nxt; pd_r <= pd_nxt; ps_r <= ps_nxt; pv_r <= pv_nxt;
            psl_r <= psl_nxt; err_r <= err_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign o_busy = busy_r;
    assign o_mem_req = req_r;
    assign o_mem_we = we_r;
    assign o_mem_byte = mb_r;
    assign o_mem_addr = addr_r;
    assign o_mem_wdata = wd_r;
    assign o_pop_data = pd_r;
    assign o_pop_valid = pv_r;
    assign o_processor_status_word = ps_r;
    assign o_ps_load = psl_r;
    assign o_hardware_stack_pointer = regs_r[`STL_SP_IDX];
    assign o_program_counter_register = regs_r[`STL_PC_IDX];
    assign o_op_error = err_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_sp_even;
        @(posedge i_clk) disable iff (i_sys_rst)
        regs_r[`STL_SP_IDX][0] == 1'b0 && !(o_mem_req && sel_r == 3'h6 && o_mem_byte);
    endproperty
    a_sp_even: assert property (p_sp_even) else $error("sp odd"); // [R5]
    property p_push_dec;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r == stl_pkg::STL_IDLE && i_op == stl_pkg::STL_OP_PUSH && i_reg == 3'h1 && !i_byte)
        |=> regs_r[1] == 16'($past(regs_r[1]) - 16'h0002) && o_mem_addr == regs_r[1] && o_mem_we;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push step wrong"); // [R6]
    property p_pop_inc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r == stl_pkg::STL_POP_RD && i_mem_ack && sel_r != 3'h6 && byte_r)
        |=> regs_r[sel_r] == 16'($past(regs_r[sel_r]) + 16'h0001) && o_pop_valid;
    endproperty
    a_pop_inc: assert property (p_pop_inc) else $error("byte pop step wrong"); // [R14]
    property p_call_push;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r == stl_pkg::STL_IDLE && i_op == stl_pkg::STL_OP_CALL)
        |=> o_mem_we && o_mem_req && o_mem_addr == o_hardware_stack_pointer
            && o_mem_wdata == $past(regs_r[i_reg]);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call did not push"); // [R8]
    property p_call_jump;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r == stl_pkg::STL_CALL_WR && i_mem_ack)
        |=> o_program_counter_register == $past(hold_r) && !o_mem_req;
    endproperty
    a_call_jump: assert property (p_call_jump) else $error("call did not jump"); // [R9]
    property p_pc_not_ptr;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r == stl_pkg::STL_IDLE && i_op == stl_pkg::STL_OP_PUSH && i_reg == 3'h7)
        |=> o_op_error && !o_mem_req;
    endproperty
    a_pc_not_ptr: assert property (p_pc_not_ptr) else $error("pc used as pointer"); // [R3]
    property p_int_seq;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r == stl_pkg::STL_INT_PS && i_mem_ack)
        |=> st_r == stl_pkg::STL_INT_PC && o_mem_wdata == $past(regs_r[7]);
    endproperty
    a_int_seq: assert property (p_int_seq) else $error("interrupt pc push wrong"); // [R13]
    property p_ret_pc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r == stl_pkg::STL_IDLE && i_op == stl_pkg::STL_OP_RETURN && i_reg == 3'h5)
        |=> o_program_counter_register == $past(regs_r[5]);
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong"); // [R12]
endmodule : stl_linkage

// [logic/stl_step.sv]
`timescale 1ns/1ps
`include "stl_regs.svh"
// pointer step: sp is word-only so byte requests on it still move by two
module stl_step (
    input  wire logic [2:0]  i_reg,
    input  wire logic        i_byte,
    input  wire logic [15:0] i_val,
    input  wire logic        i_up,
    output logic      [15:0] o_val
);
    logic [15:0] step;
    always_comb begin
        step  = (i_byte && i_reg != `STL_SP_IDX) ? `STL_BYTE_STEP : `STL_WORD_STEP; // [R14] [R4] [R5]
        o_val = i_up ? 16'(i_val + step) : 16'(i_val - step);
    end
endmodule : stl_step

// [shared/stl_pkg.sv]
package stl_pkg;
    typedef enum logic [7:0] {
        STL_OP_NONE    = 8'h01,
        STL_OP_PUSH    = 8'h02,
        STL_OP_POP     = 8'h04,
        STL_OP_CALL    = 8'h08,
        STL_OP_RETURN  = 8'h10,
        STL_OP_INTR    = 8'h20,
        STL_OP_RTI     = 8'h40,
        STL_OP_ARGINC  = 8'h80
    } stl_op_e;
    typedef enum logic [9:0] {
        STL_IDLE     = 10'h001,
        STL_PUSH_WR  = 10'h002,
        STL_POP_RD   = 10'h004,
        STL_CALL_WR  = 10'h008,
        STL_RET_RD   = 10'h010,
        STL_INT_PS   = 10'h020,
        STL_INT_PC   = 10'h040,
        STL_VEC_PC   = 10'h080,
        STL_VEC_PS   = 10'h100,
        STL_RTI_PS   = 10'h200
    } stl_state_e;
    typedef logic [15:0] stl_word_t;
endpackage : stl_pkg

// [shared/stl_regs.svh]
`ifndef STL_REGS_SVH
`define STL_REGS_SVH
`define STL_SP_IDX     3'h6
`define STL_PC_IDX     3'h7
`define STL_WORD_STEP  16'h0002
`define STL_BYTE_STEP  16'h0001
`define STL_RST_WORD   16'h0000
`endif

// [tb/stl_linkage_tb.sv]
`timescale 1ns/1ps
module stl_linkage_tb;
    logic             i_clk, i_sys_rst, i_byte, mem_ack, busy, req, we, mbyte;
    logic             pop_valid, ps_load, op_error, seen_pop, seen_ps, seen_err, last_byte;
    stl_pkg::stl_op_e i_op;
    logic [2:0]       i_reg;
    logic [3:0]       delay;
    logic [15:0]      i_data, i_entry, i_vector, i_ps, rdata, addr, wdata, pop_data;
    logic [15:0]      ps_out, sp, pc, pop_cap, last_addr;
    int               fail_count, num_checks, acc_count, acc0;
    stl_linkage dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_op(i_op), .i_reg(i_reg),
        .i_byte(i_byte), .i_data(i_data), .i_entry(i_entry), .i_vector(i_vector),
        .i_processor_status_word(i_ps), .i_mem_ack(mem_ack), .i_mem_rdata(rdata),
        .o_busy(busy), .o_mem_req(req), .o_mem_we(we), .o_mem_byte(mbyte),
        .o_mem_addr(addr), .o_mem_wdata(wdata), .o_pop_data(pop_data),
        .o_pop_valid(pop_valid), .o_processor_status_word(ps_out), .o_ps_load(ps_load),
        .o_hardware_stack_pointer(sp), .o_program_counter_register(pc),
        .o_op_error(op_error));
    stl_mem_model m (.i_clk(i_clk), .i_req(req), .i_we(we), .i_byte(mbyte), .i_addr(addr),
        .i_wdata(wdata), .i_delay(delay), .o_ack(mem_ack), .o_rdata(rdata));
    always #10 i_clk = ~i_clk;
    // one-cycle pulses are latched so a scenario can judge them afterwards
    always @(posedge i_clk) begin
        if (pop_valid) begin
            seen_pop <= 1'b1;
            pop_cap  <= pop_data;
        end
        if (ps_load) seen_ps <= 1'b1;
        if (op_error) seen_err <= 1'b1;
        if (req && mem_ack) begin
            last_addr <= addr;
            last_byte <= mbyte;
            acc_count <= acc_count + 1;
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    function automatic logic [15:0] rw(input logic [15:0] a);
        return {m.mem[a + 16'h0001], m.mem[a]};
    endfunction : rw
    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        m.mem[a]           = d[7:0];
        m.mem[a + 16'h0001] = d[15:8];
    endtask : poke
    task automatic run(input stl_pkg::stl_op_e op, input logic [2:0] r, input logic b,
                       input logic [15:0] d, input logic [3:0] dl);
        int n;
        @(posedge i_clk);
        seen_pop = 1'b0;
        seen_ps  = 1'b0;
        seen_err = 1'b0;
        i_op   <= op;
        i_reg  <= r;
        i_byte <= b;
        i_data <= d;
        delay  <= dl;
        @(posedge i_clk);
        i_op <= stl_pkg::STL_OP_NONE;
        #1;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("busy cleared", 16'h0000, {15'h0000, busy});
        @(posedge i_clk);
        #1;
    endtask : run
    task automatic t_call_intr();
        poke(16'h0040, 16'h1000);
        poke(16'h0042, 16'h00E0);
        run(stl_pkg::STL_OP_CALL, 3'h5, 1'b0, 16'h0000, 4'h0);
        chk("sp call", 16'hFFFE, sp);
        chk("saved link", 16'h0000, rw(16'hFFFE));
        chk("pc call", 16'h3000, pc);
        run(stl_pkg::STL_OP_INTR, 3'h0, 1'b0, 16'h0000, 4'h3);
        chk("status pushed", 16'h00F1, rw(16'hFFFC));
        chk("pc pushed", 16'h3000, rw(16'hFFFA));
        chk("sp intr", 16'hFFFA, sp);
        chk("pc vector", 16'h1000, pc);
        chk("status vector", 16'h00E0, ps_out);
        chk("status load", 16'h0001, {15'h0000, seen_ps});
        $display("test call and interrupt done");
    endtask : t_call_intr
    task automatic t_args_ret();
        poke(16'h1000, 16'hABCD);
        poke(16'h1002, 16'h1234);
        poke(16'h0000, 16'h5A5A);
        run(stl_pkg::STL_OP_CALL, 3'h5, 1'b0, 16'h0000, 4'h1);
        chk("sp call2", 16'hFFF8, sp);
        chk("pc call2", 16'h2000, pc);
        run(stl_pkg::STL_OP_ARGINC, 3'h5, 1'b0, 16'h0000, 4'h1);
        chk("arg one", 16'hABCD, pop_cap);
        chk("arg valid", 16'h0001, {15'h0000, seen_pop});
        run(stl_pkg::STL_OP_ARGINC, 3'h5, 1'b0, 16'h0000, 4'h0);
        chk("arg two", 16'h1234, pop_cap);
        run(stl_pkg::STL_OP_RETURN, 3'h5, 1'b1, 16'h0000, 4'h2);
        chk("pc return", 16'h1004, pc);
        chk("sp return", 16'hFFFA, sp);
        run(stl_pkg::STL_OP_ARGINC, 3'h5, 1'b0, 16'h0000, 4'h0);
        chk("link restored", 16'h5A5A, pop_cap);
        run(stl_pkg::STL_OP_RTI, 3'h0, 1'b0, 16'h0000, 4'h0);
        chk("pc rti", 16'h3000, pc);
        chk("status rti", 16'h00F1, ps_out);
        chk("sp rti", 16'hFFFE, sp);
        chk("status load rti", 16'h0001, {15'h0000, seen_ps});
        $display("test arguments and return done");
    endtask : t_args_ret
    task automatic t_stacks();
        run(stl_pkg::STL_OP_PUSH, 3'h6, 1'b1, 16'hBEEF, 4'h2);
        chk("sp byte req", 16'hFFFC, sp);
        chk("sp word only", 16'h0000, {15'h0000, last_byte});
        chk("pushed word", 16'hBEEF, rw(16'hFFFC));
        run(stl_pkg::STL_OP_PUSH, 3'h6, 1'b0, 16'h1111, 4'h0);
        chk("sp push2", 16'hFFFA, sp);
        run(stl_pkg::STL_OP_POP, 3'h6, 1'b0, 16'h0000, 4'h1);
        chk("pop last", 16'h1111, pop_cap);
        chk("sp pop", 16'hFFFC, sp);
        run(stl_pkg::STL_OP_POP, 3'h6, 1'b0, 16'h0000, 4'h0);
        chk("pop first", 16'hBEEF, pop_cap);
        chk("sp empty", 16'hFFFE, sp);
        run(stl_pkg::STL_OP_PUSH, 3'h3, 1'b1, 16'h0041, 4'h0);
        chk("byte addr", 16'hFFFF, last_addr);
        chk("byte access", 16'h0001, {15'h0000, last_byte});
        run(stl_pkg::STL_OP_PUSH, 3'h3, 1'b1, 16'h0042, 4'h1);
        chk("byte addr2", 16'hFFFE, last_addr);
        run(stl_pkg::STL_OP_POP, 3'h3, 1'b1, 16'h0000, 4'h0);
        chk("byte pop addr", 16'hFFFE, last_addr);
        run(stl_pkg::STL_OP_POP, 3'h3, 1'b1, 16'h0000, 4'h0);
        chk("byte pop addr2", 16'hFFFF, last_addr);
        chk("sp untouched", 16'hFFFE, sp);
        run(stl_pkg::STL_OP_PUSH, 3'h1, 1'b0, 16'h7777, 4'h1);
        chk("word addr", 16'hFFFE, last_addr);
        chk("word written", 16'h7777, rw(16'hFFFE));
        run(stl_pkg::STL_OP_POP, 3'h1, 1'b0, 16'h0000, 4'h0);
        chk("word pop", 16'h7777, pop_cap);
        acc0 = acc_count;
        run(stl_pkg::STL_OP_PUSH, 3'h7, 1'b0, 16'h0000, 4'h0);
        chk("pc refused", 16'h0001, {15'h0000, seen_err});
        chk("no access", acc0[15:0], acc_count[15:0]);
        $display("test stacks done");
    endtask : t_stacks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        {i_clk, i_byte, seen_pop, seen_ps, seen_err, last_byte} = '0;
        {i_reg, delay, i_data, pop_cap, last_addr} = '0;
        {fail_count, num_checks, acc_count} = '0;
        i_sys_rst = 1'b1;
        i_op      = stl_pkg::STL_OP_NONE;
        i_entry   = 16'h3000;
        i_vector  = 16'h0040;
        i_ps      = 16'h00F1;
        repeat (3) @(posedge i_clk);
        #1;
        chk("reset sp pc", 16'h0000, sp | pc | ps_out);
        chk("reset req", 16'h0000, {14'h0000, req, busy});
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_call_intr();
        @(posedge i_clk);
        i_entry <= 16'h2000;
        t_args_ret();
        t_stacks();
        end_sim();
    end
    // whole run needs well under a thousand cycles
    initial begin
        #200000;
        fail_count++;
        $display("mismatch watchdog expected done seen timeout");
        end_sim();
    end
endmodule : stl_linkage_tb

// [tb/stl_mem_model.sv]
`timescale 1ns/1ps
module stl_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic        i_byte,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [3:0]  i_delay,
    output logic             o_ack,
    output logic      [15:0] o_rdata
);
    logic [7:0] mem [0:65535];
    logic [3:0] cnt_r;
    initial begin
        o_ack   = 1'b0;
        o_rdata = 16'h0000;
        cnt_r   = 4'h0;
    end
    // read data is not held between answers, so it toggles every cycle
    always @(posedge i_clk) begin
        o_ack   <= 1'b0;
        o_rdata <= ~o_rdata;
        if (!i_req || o_ack) begin
            cnt_r <= 4'h0;
        end else if (cnt_r < i_delay) begin
            cnt_r <= cnt_r + 4'h1;
        end else begin
            o_ack   <= 1'b1;
            o_rdata <= {mem[{i_addr[15:1], 1'b1}], mem[{i_addr[15:1], 1'b0}]};
            if (i_we) begin
                mem[i_addr] <= i_wdata[7:0];
                if (!i_byte) begin
                    mem[i_addr | 16'h0001] <= i_wdata[15:8];
                end
            end
        end
    end
endmodule : stl_mem_model
